/* File: rtl/cgb_clock_gate_bank.sv */
/*
 * cgb_clock_gate_bank: APB slave holding four clock gate registers for
 * the cpu/ddr, timer/bus, ethernet and peripheral bus clocks.
 * Assumes: APB master on CLK; gate outputs feed clock gating cells that
 * stop their clock while the output is high.
 */
// Summary of operation
// - write changes a bit only where mask set
// - mask bit zero keeps the stored bit
// - gate one stops clock; reset clears all
// - cpu/ddr register: ddr apb, cpu periph, axi
// - cpu/ddr bit 2 gates the debug port
// - six timer gates, bits 10 down to 5
// - bus gates phy, apb, apb src, ahb, axi
// - eight ethernet gates in bits 7 to 0
// - peripheral bus gates apb, ahb, axi
`timescale 1ns/1ps
`default_nettype none

module cgb_clock_gate_bank
	import cgb_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              RST_N,
	// apb slave
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [ADDR_W-1:0] PADDR,
	input  wire logic [DATA_W-1:0] PWDATA,
	output logic      [DATA_W-1:0] PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	// cpu and ddr gates
	output logic                   DDR_APB_CLOCK_GATE,
	output logic                   JTAG_CLOCK_GATE,
	output logic                   CPU_PERIPH_CLOCK_GATE,
	output logic                   CPU_AXI_CLOCK_GATE,
	// timer gates
	output logic                   TIMER5_CLOCK_GATE,
	output logic                   TIMER4_CLOCK_GATE,
	output logic                   TIMER3_CLOCK_GATE,
	output logic                   TIMER2_CLOCK_GATE,
	output logic                   TIMER1_CLOCK_GATE,
	output logic                   TIMER0_CLOCK_GATE,
	// bus fabric gates
	output logic                   PHY_APB_CLOCK_GATE,
	output logic                   BUS_APB_CLOCK_GATE,
	output logic                   BUS_APB_SRC_CLOCK_GATE,
	output logic                   BUS_AHB_CLOCK_GATE,
	output logic                   BUS_AXI_CLOCK_GATE,
	// ethernet gates
	output logic                   ETH_IO_REF_GATE,
	output logic                   ETH_IO_REFOUT_GATE,
	output logic                   ETH_IO_TX_GATE,
	output logic                   ETH_IO_RX_GATE,
	output logic                   ETH_PHY_REF_GATE,
	output logic                   ETH_MACPHY_GATE,
	output logic                   ETH_PHY_RX_GATE,
	output logic                   ETH_MAC_APB_GATE,
	// peripheral bus gates
	output logic                   PERIPH_APB_CLOCK_GATE,
	output logic                   PERIPH_AHB_CLOCK_GATE,
	output logic                   PERIPH_AXI_CLOCK_GATE
);

	// register map; every word is 32 bits on an aligned byte address
	// upper half 31:16 is a write-only mask and always reads zero
	// lower half holds the gates; one stops a clock, zero runs it

	// cpu_ddr_clock_gates at 0x21c
	//   bits 15:5  reserved, read zero
	//   bit 4      ddr interface apb clock
	//   bit 3      reserved, read zero
	//   bit 2      debug port clock
	//   bit 1      cpu peripheral clock
	//   bit 0      cpu axi clock

	// timer_bus_clock_gates at 0x220
	//   bits 15:11 reserved, read zero
	//   bit 10     timer five clock
	//   bit 9      timer four clock
	//   bit 8      timer three clock
	//   bit 7      timer two clock
	//   bit 6      timer one clock
	//   bit 5      timer zero clock
	//   bit 4      phy apb clock
	//   bit 3      bus apb clock
	//   bit 2      bus apb source clock
	//   bit 1      bus ahb clock
	//   bit 0      bus axi clock

	// ethernet_clock_gates at 0x224
	//   bits 15:8  reserved, read zero
	//   bit 7      external io reference clock
	//   bit 6      reference output clock
	//   bit 5      external io transmit clock
	//   bit 4      external io receive clock
	//   bit 3      internal phy reference clock
	//   bit 2      mac to phy clock
	//   bit 1      internal phy receive clock
	//   bit 0      mac apb clock

	// periph_bus_clock_gates at 0x228
	//   bits 15:3  reserved, read zero
	//   bit 2      peripheral apb clock
	//   bit 1      peripheral ahb clock
	//   bit 0      peripheral axi clock

	// any other address answers with an error and stores nothing
	// every gate bit resets to zero, so all clocks run after reset

	// bus handshake states, one-hot
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_DONE = 2'b10
	} cgb_bus_state_t;

	// ready, slverr and rdata are the registered answer; ready stands
	// one cycle, rdata keeps its value until the next access
	typedef struct packed {
		cgb_bus_state_t    state;
		logic              ready;
		logic              slverr;
		logic [DATA_W-1:0] rdata;
	} cgb_top_state_t;

	cgb_top_state_t    st;
	cgb_top_state_t    next_st;
	logic              rst_n_sync;
	// per-register stored gates, strobes and decode
	logic [GATE_W-1:0] gate_q [NUM_REGS];
	logic [NUM_REGS-1:0] wr_sel;
	logic [2:0]        hit_idx;
	logic              access;
	logic              commit;

	// register decode: {hit, index}; used by both read and write paths
	// the full address is compared, so there are no aliases above the map
	function automatic logic [2:0] reg_decode(input logic [ADDR_W-1:0] addr);
		logic [2:0] res;
		res = 3'h0;
		if (addr == OFS_CPU_DDR) begin
			res = {1'b1, IDX_CPU_DDR};
		end else if (addr == OFS_TIMER_BUS) begin
			res = {1'b1, IDX_TIMER_BUS};
		end else if (addr == OFS_ETHERNET) begin
			res = {1'b1, IDX_ETHERNET};
		end else if (addr == OFS_PERIPH_BUS) begin
			res = {1'b1, IDX_PERIPH_BUS};
		end
		return res;
	endfunction : reg_decode

	// release reset cleanly into the rest of the block
	// the bank stays in reset two edges after RST_N rises, so the first
	// access should come no sooner than the third edge
	cgb_rst_sync u_rst_sync (
		.clk        (CLK),
		.rst_n      (RST_N),
		.rst_n_sync (rst_n_sync)
	);

	// address decode and access qualifiers
	assign hit_idx = reg_decode(PADDR);
	assign access  = PSEL && PENABLE;
	// the transfer ends at the edge where PREADY is seen high
	assign commit  = access && st.ready && (st.state == ST_DONE);

	// one write strobe per register, only on the completing edge
	// strobing there, not at the access edge, keeps a transfer cut short
	// by reset from touching any gate
	always_comb begin
		wr_sel = '0;
		if (commit && PWRITE && hit_idx[2]) begin
			wr_sel[hit_idx[1:0]] = 1'b1;
		end
	end

	// gate registers, one per word
	// the mask is applied inside each register, so the bus side only
	// steers one strobe; the write word is shared by all four
	generate
		for (genvar i = 0; i < NUM_REGS; i++) begin : gen_reg
			cgb_gate_if u_if ();

			assign u_if.wr    = wr_sel[i];
			assign u_if.wdata = PWDATA;
			assign gate_q[i]  = u_if.q;

			// masked write keeps unmasked bits
			cgb_gate_reg #(
				.VALID (VALID_MASKS[i])   // reserved bits never stored
			) u_gate (
				.clk   (CLK),
				.rst_n (rst_n_sync),
				.port  (u_if.store)
			);
		end
	endgenerate

	// apb handshake: one wait state, answer registered
	// edge 1: setup seen, nothing happens yet
	// edge 2: access seen while idle; answer, error and read word are
	//         captured, so a read returns the value before any write
	// edge 3: ready seen high by the master; a write commits here
	// edge 4: ready low again, gate outputs show the new value
	// a fixed wait keeps the read path a plain flop, at the cost of one
	// extra cycle per access; an access is never stretched further
	always_comb begin
		next_st = st;
		case (st.state)
			// an access to an unmapped word is answered, never left hanging
			ST_IDLE: begin
				if (access) begin
					next_st.state  = ST_DONE;
					next_st.ready  = 1'b1;
					next_st.slverr = ~hit_idx[2];   // unmapped address
					next_st.rdata  = READ_ZERO;
					// mask field and reserved bits read zero
					if (!PWRITE && hit_idx[2]) begin
						next_st.rdata = {{(DATA_W-GATE_W){1'b0}}, gate_q[hit_idx[1:0]]};
					end
				end
			end
			ST_DONE: begin
				// master drops the access right after the completing edge
				next_st.state  = ST_IDLE;
				next_st.ready  = 1'b0;
				next_st.slverr = 1'b0;
			end
			// unreachable codes fall back to idle with no answer pending
			default: begin
				next_st.state  = ST_IDLE;
				next_st.ready  = 1'b0;
				next_st.slverr = 1'b0;
			end
		endcase
	end

	// answer flops; reset clears ready so that a stale answer cannot
	// complete a transfer that reset has cut
	always_ff @(posedge CLK or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			st.state  <= ST_IDLE;
			st.ready  <= 1'b0;
			st.slverr <= 1'b0;
			st.rdata  <= READ_ZERO;
		end else begin
			st <= next_st;
		end
	end

	assign PRDATA  = st.rdata;
	assign PREADY  = st.ready;
	assign PSLVERR = st.slverr;

	// every gate pin is a register bit with no logic after the flop, so
	// a gate cannot glitch while software rewrites other bits
	// cpu and ddr clocks; high stops the clock, reset runs all
	// bit 3 between the ddr and debug gates is reserved
	assign DDR_APB_CLOCK_GATE    = gate_q[IDX_CPU_DDR][BIT_DDR_APB];
	assign JTAG_CLOCK_GATE       = gate_q[IDX_CPU_DDR][BIT_JTAG];
	assign CPU_PERIPH_CLOCK_GATE = gate_q[IDX_CPU_DDR][BIT_CPU_PERIPH];
	assign CPU_AXI_CLOCK_GATE    = gate_q[IDX_CPU_DDR][BIT_CPU_AXI];

	// timers sit in descending order from timer five
	// a timer's gate sits at its own number plus five
	assign TIMER5_CLOCK_GATE = gate_q[IDX_TIMER_BUS][BIT_TIMER5];
	assign TIMER4_CLOCK_GATE = gate_q[IDX_TIMER_BUS][BIT_TIMER0 + 4];
	assign TIMER3_CLOCK_GATE = gate_q[IDX_TIMER_BUS][BIT_TIMER0 + 3];
	assign TIMER2_CLOCK_GATE = gate_q[IDX_TIMER_BUS][BIT_TIMER0 + 2];
	assign TIMER1_CLOCK_GATE = gate_q[IDX_TIMER_BUS][BIT_TIMER0 + 1];
	assign TIMER0_CLOCK_GATE = gate_q[IDX_TIMER_BUS][BIT_TIMER0];

	// bus fabric clocks share the timer word
	// these bits are independent of the timer gates above them
	assign PHY_APB_CLOCK_GATE     = gate_q[IDX_TIMER_BUS][BIT_PHY_APB];
	assign BUS_APB_CLOCK_GATE     = gate_q[IDX_TIMER_BUS][BIT_BUS_APB];
	assign BUS_APB_SRC_CLOCK_GATE = gate_q[IDX_TIMER_BUS][BIT_BUS_APB_SRC];
	assign BUS_AHB_CLOCK_GATE     = gate_q[IDX_TIMER_BUS][BIT_BUS_AHB];
	assign BUS_AXI_CLOCK_GATE     = gate_q[IDX_TIMER_BUS][BIT_BUS_AXI];

	// ethernet clocks
	// external io gates in the upper four bits, internal phy and mac gates in the lower
	assign ETH_IO_REF_GATE    = gate_q[IDX_ETHERNET][BIT_ETH_IO_REF];
	assign ETH_IO_REFOUT_GATE = gate_q[IDX_ETHERNET][BIT_ETH_IO_REFOUT];
	assign ETH_IO_TX_GATE     = gate_q[IDX_ETHERNET][BIT_ETH_IO_TX];
	assign ETH_IO_RX_GATE     = gate_q[IDX_ETHERNET][BIT_ETH_IO_RX];
	assign ETH_PHY_REF_GATE   = gate_q[IDX_ETHERNET][BIT_ETH_PHY_REF];
	assign ETH_MACPHY_GATE    = gate_q[IDX_ETHERNET][BIT_ETH_MACPHY];
	assign ETH_PHY_RX_GATE    = gate_q[IDX_ETHERNET][BIT_ETH_PHY_RX];
	assign ETH_MAC_APB_GATE   = gate_q[IDX_ETHERNET][BIT_ETH_MAC_APB];

	// peripheral bus clocks; stopping apb here does not stop this block
	assign PERIPH_APB_CLOCK_GATE = gate_q[IDX_PERIPH_BUS][BIT_PERIPH_APB];
	assign PERIPH_AHB_CLOCK_GATE = gate_q[IDX_PERIPH_BUS][BIT_PERIPH_AHB];
	assign PERIPH_AXI_CLOCK_GATE = gate_q[IDX_PERIPH_BUS][BIT_PERIPH_AXI];

endmodule : cgb_clock_gate_bank

`default_nettype wire

/* File: rtl/cgb_gate_if.sv */
/*
 * cgb_gate_if: write strobe, write word and stored gates between the
 * bus logic and one gate register.
 * Assumes: one instance per register, all on the bus clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface cgb_gate_if;
	import cgb_pkg::*;
	logic                 wr;
	logic [DATA_W-1:0]    wdata;
	logic [GATE_W-1:0]    q;

	modport ctrl  (output wr, output wdata, input q);
	modport store (input wr, input wdata, output q);
endinterface : cgb_gate_if

`default_nettype wire

/* File: rtl/cgb_gate_reg.sv */
/*
 * cgb_gate_reg: one 16-bit gate register with a per-bit write mask in
 * the upper half of the written word.
 * Assumes: wr is a single-cycle strobe on the bus clock.
 */
`timescale 1ns/1ps
`default_nettype none

module cgb_gate_reg
	import cgb_pkg::*;
#(
	parameter logic [GATE_W-1:0] VALID = 16'hffff
)
(
	input  wire logic  clk,
	input  wire logic  rst_n,
	cgb_gate_if.store  port
);

	typedef struct packed {
		logic [GATE_W-1:0] gate;
	} cgb_gate_state_t;

	cgb_gate_state_t st;
	cgb_gate_state_t next_st;
	logic [GATE_W-1:0] mask;

	assign mask = port.wdata[DATA_W-1:MASK_LSB];

	// masked update; reserved positions never store a one
	always_comb begin
		next_st = st;
		if (port.wr) begin
			next_st.gate = ((st.gate & ~mask) | (port.wdata[GATE_W-1:0] & mask))
				& VALID;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st.gate <= GATE_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign port.q = st.gate;

endmodule : cgb_gate_reg

`default_nettype wire

/* File: rtl/cgb_pkg.sv */
/*
 * cgb_pkg: register map, field positions and reset values for the
 * clock gate bank (four masked-write gate registers).
 * Assumes: a byte-addressed 32-bit APB register space, one word a register.
 */
package cgb_pkg;

	// bus geometry
	localparam int ADDR_W   = 12;
	localparam int DATA_W   = 32;
	localparam int GATE_W   = 16;
	localparam int NUM_REGS = 4;
	localparam int MASK_LSB = 16;   // write mask field is [31:16]
	localparam int SYNC_LEN = 2;    // reset release flops

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CPU_DDR     = 12'h21c;
	localparam logic [ADDR_W-1:0] OFS_TIMER_BUS   = 12'h220;
	localparam logic [ADDR_W-1:0] OFS_ETHERNET    = 12'h224;
	localparam logic [ADDR_W-1:0] OFS_PERIPH_BUS  = 12'h228;

	// register indices
	localparam logic [1:0] IDX_CPU_DDR    = 2'h0;
	localparam logic [1:0] IDX_TIMER_BUS  = 2'h1;
	localparam logic [1:0] IDX_ETHERNET   = 2'h2;
	localparam logic [1:0] IDX_PERIPH_BUS = 2'h3;

	// implemented gate bits per register; all others are reserved
	localparam logic [GATE_W-1:0] VALID_MASKS [NUM_REGS] = '{
		16'h0017, 16'h07ff, 16'h00ff, 16'h0007};

	localparam logic [GATE_W-1:0] GATE_RESET = 16'h0000;  // every clock runs
	localparam logic [DATA_W-1:0] READ_ZERO  = 32'h0000_0000;

	// cpu and ddr register fields
	localparam int BIT_DDR_APB     = 4;
	localparam int BIT_JTAG        = 2;
	localparam int BIT_CPU_PERIPH  = 1;
	localparam int BIT_CPU_AXI     = 0;

	// timer and bus register fields
	localparam int BIT_TIMER5      = 10;
	localparam int BIT_TIMER0      = 5;
	localparam int BIT_PHY_APB     = 4;
	localparam int BIT_BUS_APB     = 3;
	localparam int BIT_BUS_APB_SRC = 2;
	localparam int BIT_BUS_AHB     = 1;
	localparam int BIT_BUS_AXI     = 0;

	// ethernet register fields
	localparam int BIT_ETH_IO_REF    = 7;
	localparam int BIT_ETH_IO_REFOUT = 6;
	localparam int BIT_ETH_IO_TX     = 5;
	localparam int BIT_ETH_IO_RX     = 4;
	localparam int BIT_ETH_PHY_REF   = 3;
	localparam int BIT_ETH_MACPHY    = 2;
	localparam int BIT_ETH_PHY_RX    = 1;
	localparam int BIT_ETH_MAC_APB   = 0;

	// peripheral bus register fields
	localparam int BIT_PERIPH_APB  = 2;
	localparam int BIT_PERIPH_AHB  = 1;
	localparam int BIT_PERIPH_AXI  = 0;

endpackage : cgb_pkg

/* File: rtl/cgb_rst_sync.sv */
/*
 * cgb_rst_sync: asynchronous assert, synchronous release of reset.
 * Assumes: rst_n may be released at any time relative to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module cgb_rst_sync
	import cgb_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	output logic      rst_n_sync
);

	typedef struct packed {
		logic [SYNC_LEN-1:0] sync;
	} cgb_sync_state_t;

	cgb_sync_state_t st;
	cgb_sync_state_t next_st;

	// shift ones in after release; only the last stage is read
	always_comb begin
		next_st = st;
		next_st.sync = {st.sync[SYNC_LEN-2:0], 1'b1};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rst_n_sync = st.sync[SYNC_LEN-1];

endmodule : cgb_rst_sync

`default_nettype wire

/* File: test/cgb_checker.sv */
/*
 * cgb_checker: bus timing and gate update properties of the gate bank.
 * Assumes: bound to the top module, watching its ports only.
 */
`timescale 1ns/1ps
`default_nettype none

module cgb_checker
	import cgb_pkg::*;
(
	input wire logic              CLK,
	input wire logic              RST_N,
	input wire logic              PSEL,
	input wire logic              PENABLE,
	input wire logic              PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [DATA_W-1:0] PWDATA,
	input wire logic [DATA_W-1:0] PRDATA,
	input wire logic              PREADY,
	input wire logic              PSLVERR,
	input wire logic              TIMER5_CLOCK_GATE,
	input wire logic              JTAG_CLOCK_GATE,
	input wire logic              ETH_IO_REF_GATE,
	input wire logic              PERIPH_APB_CLOCK_GATE,
	input wire logic              PERIPH_AHB_CLOCK_GATE,
	input wire logic              PERIPH_AXI_CLOCK_GATE
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	// decoded address and completing write
	logic mapped;
	logic wr_done;
	assign mapped  = PADDR inside {OFS_CPU_DDR, OFS_TIMER_BUS, OFS_ETHERNET, OFS_PERIPH_BUS};
	assign wr_done = PSEL && PENABLE && PREADY && PWRITE;

	a_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("ready missing after access");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready held too long");
	a_err_map: assert property (PREADY |-> PSLVERR == !mapped)
		else $error("error flag wrong for address");
	a_mask_zero: assert property (PREADY |-> PRDATA[31:16] == 16'h0000)
		else $error("mask field read nonzero");
	a_rsvd_zero: assert property (PREADY && !PWRITE && PADDR == OFS_CPU_DDR |->
		PRDATA[15:5] == 11'h000 && !PRDATA[3]) else $error("reserved bits read nonzero");
	a_timer_set: assert property (wr_done && PADDR == OFS_TIMER_BUS && PWDATA[26] |=>
		TIMER5_CLOCK_GATE == $past(PWDATA[10])) else $error("timer gate not written");
	a_timer_keep: assert property (wr_done && PADDR == OFS_TIMER_BUS && !PWDATA[26] |=>
		$stable(TIMER5_CLOCK_GATE)) else $error("timer gate changed unmasked");
	a_jtag_set: assert property (wr_done && PADDR == OFS_CPU_DDR && PWDATA[18] |=>
		JTAG_CLOCK_GATE == $past(PWDATA[2])) else $error("debug gate not written");
	a_eth_set: assert property (wr_done && PADDR == OFS_ETHERNET && PWDATA[23] |=>
		ETH_IO_REF_GATE == $past(PWDATA[7])) else $error("eth ref gate not written");
	a_periph_read: assert property (PREADY && !PWRITE && PADDR == OFS_PERIPH_BUS |->
		PRDATA[2:0] == {PERIPH_APB_CLOCK_GATE, PERIPH_AHB_CLOCK_GATE, PERIPH_AXI_CLOCK_GATE})
		else $error("peripheral gate readback wrong");

	c_write: cover property (wr_done && mapped);
	c_error: cover property (PREADY && PSLVERR);
	c_timer: cover property (wr_done && PADDR == OFS_TIMER_BUS && PWDATA[26]);
endmodule : cgb_checker

bind cgb_clock_gate_bank cgb_checker u_cgb_checker (
	.CLK                   (CLK),
	.RST_N                 (RST_N),
	.PSEL                  (PSEL),
	.PENABLE               (PENABLE),
	.PWRITE                (PWRITE),
	.PADDR                 (PADDR),
	.PWDATA                (PWDATA),
	.PRDATA                (PRDATA),
	.PREADY                (PREADY),
	.PSLVERR               (PSLVERR),
	.TIMER5_CLOCK_GATE     (TIMER5_CLOCK_GATE),
	.JTAG_CLOCK_GATE       (JTAG_CLOCK_GATE),
	.ETH_IO_REF_GATE       (ETH_IO_REF_GATE),
	.PERIPH_APB_CLOCK_GATE (PERIPH_APB_CLOCK_GATE),
	.PERIPH_AHB_CLOCK_GATE (PERIPH_AHB_CLOCK_GATE),
	.PERIPH_AXI_CLOCK_GATE (PERIPH_AXI_CLOCK_GATE)
);

`default_nettype wire

/* File: test/cgb_clock_gate_bank_tb.sv */
/*
 * cgb_clock_gate_bank_tb: masked writes, readback, gate pins and reset.
 * Assumes: the bank answers each access with one wait state.
 */
`timescale 1ns/1ps
`default_nettype none

module cgb_clock_gate_bank_tb
	import cgb_pkg::*;
;
	logic              CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [ADDR_W-1:0] PADDR = '0;
	logic [DATA_W-1:0] PWDATA = '0, PRDATA, rd;
	logic              PREADY, PSLVERR, err;
	logic DDR_APB_CLOCK_GATE, JTAG_CLOCK_GATE, CPU_PERIPH_CLOCK_GATE, CPU_AXI_CLOCK_GATE;
	logic TIMER5_CLOCK_GATE, TIMER4_CLOCK_GATE, TIMER3_CLOCK_GATE, TIMER2_CLOCK_GATE;
	logic TIMER1_CLOCK_GATE, TIMER0_CLOCK_GATE, PHY_APB_CLOCK_GATE, BUS_APB_CLOCK_GATE;
	logic BUS_APB_SRC_CLOCK_GATE, BUS_AHB_CLOCK_GATE, BUS_AXI_CLOCK_GATE;
	logic ETH_IO_REF_GATE, ETH_IO_REFOUT_GATE, ETH_IO_TX_GATE, ETH_IO_RX_GATE;
	logic ETH_PHY_REF_GATE, ETH_MACPHY_GATE, ETH_PHY_RX_GATE, ETH_MAC_APB_GATE;
	logic PERIPH_APB_CLOCK_GATE, PERIPH_AHB_CLOCK_GATE, PERIPH_AXI_CLOCK_GATE;
	wire  [GATE_W-1:0] obs [NUM_REGS];
	logic [GATE_W-1:0] model [NUM_REGS];
	logic [ADDR_W-1:0] ofs [NUM_REGS] = '{OFS_CPU_DDR, OFS_TIMER_BUS, OFS_ETHERNET, OFS_PERIPH_BUS};
	logic [31:0]       rnd = 32'hc84d30fb;
	int                failures = 0, cmp_count = 0, cyc = 0;

	cgb_clock_gate_bank u_cgb_clock_gate_bank (
		.CLK                    (CLK),
		.RST_N                  (RST_N),
		.PSEL                   (PSEL),
		.PENABLE                (PENABLE),
		.PWRITE                 (PWRITE),
		.PADDR                  (PADDR),
		.PWDATA                 (PWDATA),
		.PRDATA                 (PRDATA),
		.PREADY                 (PREADY),
		.PSLVERR                (PSLVERR),
		.DDR_APB_CLOCK_GATE     (DDR_APB_CLOCK_GATE),
		.JTAG_CLOCK_GATE        (JTAG_CLOCK_GATE),
		.CPU_PERIPH_CLOCK_GATE  (CPU_PERIPH_CLOCK_GATE),
		.CPU_AXI_CLOCK_GATE     (CPU_AXI_CLOCK_GATE),
		.TIMER5_CLOCK_GATE      (TIMER5_CLOCK_GATE),
		.TIMER4_CLOCK_GATE      (TIMER4_CLOCK_GATE),
		.TIMER3_CLOCK_GATE      (TIMER3_CLOCK_GATE),
		.TIMER2_CLOCK_GATE      (TIMER2_CLOCK_GATE),
		.TIMER1_CLOCK_GATE      (TIMER1_CLOCK_GATE),
		.TIMER0_CLOCK_GATE      (TIMER0_CLOCK_GATE),
		.PHY_APB_CLOCK_GATE     (PHY_APB_CLOCK_GATE),
		.BUS_APB_CLOCK_GATE     (BUS_APB_CLOCK_GATE),
		.BUS_APB_SRC_CLOCK_GATE (BUS_APB_SRC_CLOCK_GATE),
		.BUS_AHB_CLOCK_GATE     (BUS_AHB_CLOCK_GATE),
		.BUS_AXI_CLOCK_GATE     (BUS_AXI_CLOCK_GATE),
		.ETH_IO_REF_GATE        (ETH_IO_REF_GATE),
		.ETH_IO_REFOUT_GATE     (ETH_IO_REFOUT_GATE),
		.ETH_IO_TX_GATE         (ETH_IO_TX_GATE),
		.ETH_IO_RX_GATE         (ETH_IO_RX_GATE),
		.ETH_PHY_REF_GATE       (ETH_PHY_REF_GATE),
		.ETH_MACPHY_GATE        (ETH_MACPHY_GATE),
		.ETH_PHY_RX_GATE        (ETH_PHY_RX_GATE),
		.ETH_MAC_APB_GATE       (ETH_MAC_APB_GATE),
		.PERIPH_APB_CLOCK_GATE  (PERIPH_APB_CLOCK_GATE),
		.PERIPH_AHB_CLOCK_GATE  (PERIPH_AHB_CLOCK_GATE),
		.PERIPH_AXI_CLOCK_GATE  (PERIPH_AXI_CLOCK_GATE)
	);

	// gate pins regrouped by register bit position
	assign obs[0] = {11'h000, DDR_APB_CLOCK_GATE, 1'b0, JTAG_CLOCK_GATE,
		CPU_PERIPH_CLOCK_GATE, CPU_AXI_CLOCK_GATE};
	assign obs[1] = {5'h00, TIMER5_CLOCK_GATE, TIMER4_CLOCK_GATE, TIMER3_CLOCK_GATE,
		TIMER2_CLOCK_GATE, TIMER1_CLOCK_GATE, TIMER0_CLOCK_GATE, PHY_APB_CLOCK_GATE,
		BUS_APB_CLOCK_GATE, BUS_APB_SRC_CLOCK_GATE, BUS_AHB_CLOCK_GATE, BUS_AXI_CLOCK_GATE};
	assign obs[2] = {8'h00, ETH_IO_REF_GATE, ETH_IO_REFOUT_GATE, ETH_IO_TX_GATE, ETH_IO_RX_GATE,
		ETH_PHY_REF_GATE, ETH_MACPHY_GATE, ETH_PHY_RX_GATE, ETH_MAC_APB_GATE};
	assign obs[3] = {13'h0000, PERIPH_APB_CLOCK_GATE, PERIPH_AHB_CLOCK_GATE, PERIPH_AXI_CLOCK_GATE};

	// free running bus clock
	always #12.5 CLK = ~CLK;

	// cycle ceiling, generous over the expected 1600 or so
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			results();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic logic [15:0] upd(input logic [15:0] old, input logic [31:0] d,
		input logic [15:0] v);
		return ((old & ~d[31:16]) | (d[15:0] & d[31:16])) & v;
	endfunction : upd

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// one apb transfer; request held until ready is sampled high
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : xfer

	task automatic cmp_all();
		@(posedge CLK);
		for (int j = 0; j < NUM_REGS; j++) begin
			check("gates", {16'h0, obs[j]}, {16'h0, model[j]});
			xfer(1'b0, ofs[j], 32'h0);
			check("readback", rd, {16'h0, model[j]});
			check("read slverr", {31'h0, err}, 32'h0);
		end
	endtask : cmp_all

	task automatic wr_chk(input int i, input logic [31:0] d);
		xfer(1'b1, ofs[i], d);
		check("slverr", {31'h0, err}, 32'h0);
		model[i] = upd(model[i], d, VALID_MASKS[i]);
		cmp_all();
	endtask : wr_chk

	task automatic results();
		$display("comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results

	// main sequence
	initial begin
		model = '{default: 16'h0};
		repeat (10) @(posedge CLK);
		RST_N <= 1'b1;
		repeat (4) @(posedge CLK);
		cmp_all();
		for (int i = 0; i < NUM_REGS; i++) begin
			wr_chk(i, 32'h0000ffff);
			wr_chk(i, 32'hffffffff);
			wr_chk(i, 32'h5555aaaa);
		end
		// unmapped neighbour is refused and leaves state alone
		xfer(1'b1, 12'h22c, 32'hffffffff);
		check("slverr", {31'h0, err}, 32'h1);
		xfer(1'b0, 12'h22c, 32'h0);
		check("rdata", rd, 32'h0);
		cmp_all();
		repeat (60) begin
			rnd = lfsr(rnd);
			wr_chk(int'(rnd[1:0]), lfsr(rnd ^ 32'h9e3779b9));
		end
		// mid-run reset must restart every clock
		@(posedge CLK);
		RST_N <= 1'b0;
		repeat (3) @(posedge CLK);
		model = '{default: 16'h0};
		for (int j = 0; j < NUM_REGS; j++) check("reset", {16'h0, obs[j]}, 32'h0);
		RST_N <= 1'b1;
		repeat (4) @(posedge CLK);
		cmp_all();
		results();
	end
endmodule : cgb_clock_gate_bank_tb

`default_nettype wire
